// >>> design/mbs_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Act only on own node address, valid from 1 to 247.
// - Transmitter silent except when answering a request addressed here.
// - Answer carries own address, echoed function, data, checksum appended downstream.
// - One command at a time; bytes arriving while busy are ignored.
// - Also accept requests sent to the broadcast address.
// - Multi-byte values travel most significant byte first.
// - Serve function codes 01, 02, 03, 04, 05, 06, 15 and 16.
// - Function 03 returns holding registers over the requested range.
// - Function 04 returns input registers over the requested range.
// - 01 reads coils, 02 discrete inputs, 05 one coil, 0F many coils.
// - Register writes hit holding registers only: 06 single, 10 block.
// - Keep coils, discrete inputs, input registers and holding registers.
// - Each access is a start address plus an item count.
// - A 4-byte value spans two adjacent registers, count doubled.
// - One Boolean per coil; true sets, false clears.
// - Unknown function answers illegal-function.
// - Span outside the provided storage answers illegal-data-address.
module mbs_slave (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Node identity
  input wire logic [7:0] node_addr,
  // Request bytes, checksum already checked and removed
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_error,
  // Response bytes, checksum added downstream
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  // Storage
  input wire logic [mbs_pkg::N_DISC-1:0] discrete_in,
  input wire logic [mbs_pkg::N_IREG*mbs_pkg::WORD_W-1:0] input_regs,
  output logic [mbs_pkg::N_COILS-1:0] coil_state,
  output logic [mbs_pkg::N_HREG*mbs_pkg::WORD_W-1:0] hold_state,
  // Status
  output logic busy,
  output logic write_done
);
  mbs_pkg::mbs_state_t state, next_state;
  logic [4:0] rx_idx;
  logic rx_ovf, rx_bad, mine, bcast;
  logic [7:0] func, bcnt, exc, next_exc, tx_byte, rd_bcnt;
  logic [15:0] start, value, cnt_eff;
  logic [7:0] wbuf [mbs_pkg::WBUF_DEPTH];
  logic [4:0] tx_idx, resp_last, next_resp_last, dk;
  logic [8:0] exp_len;
  logic fn_known, fn_bits, fn_words, fn_echo, len_ok, drop, rng_ok, val_ok, do_write;
  logic ok_coil, ok_disc, ok_ireg, ok_hreg, room, load, frame_end, addr_hit;
  logic [2:0] word_sel;
  int bit_idx;

  // ----------------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------------
  // Own address only counts when it is a legal node address
  assign addr_hit = (rx_data == node_addr) && (node_addr >= mbs_pkg::ADDR_MIN)
                    && (node_addr <= mbs_pkg::ADDR_MAX);
  assign frame_end = rx_valid && rx_last && (state == mbs_pkg::ST_RECV);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_idx <= mbs_pkg::POS_ADDR;
      rx_ovf <= 1'b0;
      rx_bad <= 1'b0;
      mine <= 1'b0;
      bcast <= 1'b0;
    end else if (rx_valid && state == mbs_pkg::ST_IDLE) begin
      rx_idx <= mbs_pkg::POS_FUNC;
      rx_ovf <= 1'b0;
      rx_bad <= rx_error;
      mine <= addr_hit;
      bcast <= (rx_data == mbs_pkg::ADDR_BCAST);
    end else if (rx_valid && state == mbs_pkg::ST_RECV) begin
      rx_bad <= rx_bad || rx_error;
      if (rx_idx == mbs_pkg::RX_IDX_MAX) begin
        rx_ovf <= 1'b1;
      end else begin
        rx_idx <= rx_idx + 5'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      func <= 8'h00;
      start <= 16'h0000;
      value <= 16'h0000;
      bcnt <= 8'h00;
    end else if (rx_valid && state == mbs_pkg::ST_RECV && !rx_ovf) begin
      // Big-endian fields: high byte arrives first
      unique case (rx_idx)
        mbs_pkg::POS_FUNC: func <= rx_data;
        mbs_pkg::POS_START_HI: start[15:8] <= rx_data;
        mbs_pkg::POS_START_LO: start[7:0] <= rx_data;
        mbs_pkg::POS_CNT_HI: value[15:8] <= rx_data;
        mbs_pkg::POS_CNT_LO: value[7:0] <= rx_data;
        mbs_pkg::POS_BCNT: bcnt <= rx_data;
        default: ;
      endcase
    end
  end

  // Write data is held until the whole frame is checked, so a bad
  // request never leaves storage half updated
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < mbs_pkg::WBUF_DEPTH; i++) begin
        wbuf[i] <= 8'h00;
      end
    end else if (rx_valid && state == mbs_pkg::ST_RECV && rx_idx >= mbs_pkg::POS_DATA
                 && int'(rx_idx - mbs_pkg::POS_DATA) < mbs_pkg::WBUF_DEPTH) begin
      wbuf[int'(rx_idx - mbs_pkg::POS_DATA)] <= rx_data;
    end
  end

  // ----------------------------------------------------------------------
  // Request checks
  // ----------------------------------------------------------------------
  assign fn_bits = (func == mbs_pkg::FN_RD_COILS) || (func == mbs_pkg::FN_RD_DISC);
  assign fn_words = (func == mbs_pkg::FN_RD_HOLD) || (func == mbs_pkg::FN_RD_IREG);
  assign fn_echo = (func == mbs_pkg::FN_WR_COIL) || (func == mbs_pkg::FN_WR_HOLD)
                   || (func == mbs_pkg::FN_WR_COILS) || (func == mbs_pkg::FN_WR_HOLDS);
  assign fn_known = fn_bits || fn_words || fn_echo;

  // Single writes address exactly one item
  assign cnt_eff = (func == mbs_pkg::FN_WR_COIL || func == mbs_pkg::FN_WR_HOLD)
                   ? mbs_pkg::ONE_ITEM : value;

  mbs_range_check #(.SIZE(mbs_pkg::N_COILS)) u_rng_coil (
    .start(start),
    .count(cnt_eff),
    .ok(ok_coil)
  );
  mbs_range_check #(.SIZE(mbs_pkg::N_DISC)) u_rng_disc (
    .start(start),
    .count(cnt_eff),
    .ok(ok_disc)
  );
  mbs_range_check #(.SIZE(mbs_pkg::N_IREG)) u_rng_ireg (
    .start(start),
    .count(cnt_eff),
    .ok(ok_ireg)
  );
  mbs_range_check #(.SIZE(mbs_pkg::N_HREG)) u_rng_hreg (
    .start(start),
    .count(cnt_eff),
    .ok(ok_hreg)
  );

  always_comb begin
    rng_ok = 1'b0;
    val_ok = 1'b1;
    exp_len = {4'h0, mbs_pkg::LEN_FIXED};
    unique case (func)
      mbs_pkg::FN_RD_COILS, mbs_pkg::FN_WR_COIL: rng_ok = ok_coil;
      mbs_pkg::FN_RD_DISC: rng_ok = ok_disc;
      mbs_pkg::FN_RD_IREG: rng_ok = ok_ireg;
      mbs_pkg::FN_RD_HOLD, mbs_pkg::FN_WR_HOLD: rng_ok = ok_hreg;
      mbs_pkg::FN_WR_COILS: rng_ok = ok_coil;
      mbs_pkg::FN_WR_HOLDS: rng_ok = ok_hreg;
      default: rng_ok = 1'b0;
    endcase
    if (func == mbs_pkg::FN_WR_COIL) begin
      val_ok = (value == mbs_pkg::COIL_ON) || (value == mbs_pkg::COIL_OFF);
    end else if (func == mbs_pkg::FN_WR_COILS) begin
      val_ok = (bcnt == 8'((value + 16'(mbs_pkg::BYTE_ROUND)) >> 3));
      exp_len = {1'b0, bcnt} + {4'h0, mbs_pkg::POS_DATA};
    end else if (func == mbs_pkg::FN_WR_HOLDS) begin
      val_ok = ({1'b0, bcnt} == {value[7:0], 1'b0}) && (value[15:8] == 8'h00);
      exp_len = {1'b0, bcnt} + {4'h0, mbs_pkg::POS_DATA};
    end
  end

  // Frames of a known function that are truncated, or padded to under 32 bytes, are dropped unanswered
  assign len_ok = rx_ovf || ({4'h0, rx_idx} == exp_len);
  assign drop = (rx_idx < mbs_pkg::POS_START_HI) || (fn_known && !len_ok);
  assign next_exc = !fn_known ? mbs_pkg::EXC_ILL_FUNC :
                    !rng_ok ? mbs_pkg::EXC_ILL_ADDR :
                    !val_ok ? mbs_pkg::EXC_ILL_VALUE : mbs_pkg::EXC_NONE;
  assign do_write = (state == mbs_pkg::ST_EXEC) && !drop && (next_exc == mbs_pkg::EXC_NONE);
  assign rd_bcnt = fn_bits ? 8'((value + 16'(mbs_pkg::BYTE_ROUND)) >> 3)
                           : {value[6:0], 1'b0};
  assign next_resp_last = (next_exc != mbs_pkg::EXC_NONE) ? mbs_pkg::RSP_LAST_EXC :
                          fn_echo ? mbs_pkg::RSP_LAST_ECHO :
                          5'(rd_bcnt) + mbs_pkg::POS_START_HI;

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      mbs_pkg::ST_IDLE: begin
        if (rx_valid && !rx_last) begin
          next_state = mbs_pkg::ST_RECV;
        end
      end
      mbs_pkg::ST_RECV: begin
        if (frame_end) begin
          next_state = ((mine || bcast) && !rx_bad && !rx_error)
                       ? mbs_pkg::ST_EXEC : mbs_pkg::ST_IDLE;
        end
      end
      mbs_pkg::ST_EXEC: begin
        // No answer on a shared broadcast, or the slaves would collide
        next_state = (drop || bcast) ? mbs_pkg::ST_IDLE : mbs_pkg::ST_RESP;
      end
      mbs_pkg::ST_RESP: begin
        // New requests are not looked at until the answer is out
        if (load && tx_idx == resp_last) begin
          next_state = mbs_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= mbs_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state == mbs_pkg::ST_EXEC) || (next_state == mbs_pkg::ST_RESP);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      exc <= mbs_pkg::EXC_NONE;
      resp_last <= mbs_pkg::RSP_LAST_EXC;
    end else if (state == mbs_pkg::ST_EXEC) begin
      exc <= next_exc;
      resp_last <= next_resp_last;
    end
  end

  // ----------------------------------------------------------------------
  // Storage updates
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      coil_state <= '0;
    end else if (do_write && func == mbs_pkg::FN_WR_COIL) begin
      coil_state[start[3:0]] <= (value == mbs_pkg::COIL_ON);
    end else if (do_write && func == mbs_pkg::FN_WR_COILS) begin
      // First coil of the span sits in bit 0 of the first data byte
      for (int j = 0; j < mbs_pkg::N_COILS; j++) begin
        if (j >= int'(start) && j < int'(start) + int'(value)) begin
          coil_state[j] <= wbuf[(j - int'(start)) / mbs_pkg::BYTE_W]
                               [(j - int'(start)) % mbs_pkg::BYTE_W];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_state <= '0;
    end else if (do_write && func == mbs_pkg::FN_WR_HOLD) begin
      hold_state[{start[2:0], 4'h0} +: mbs_pkg::WORD_W] <= value;
    end else if (do_write && func == mbs_pkg::FN_WR_HOLDS) begin
      for (int j = 0; j < mbs_pkg::N_HREG; j++) begin
        if (j >= int'(start) && j < int'(start) + int'(value)) begin
          hold_state[j * mbs_pkg::WORD_W +: mbs_pkg::WORD_W] <=
            {wbuf[2 * (j - int'(start))], wbuf[2 * (j - int'(start)) + 1]};
        end
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      write_done <= 1'b0;
    end else begin
      write_done <= do_write && fn_echo;
    end
  end

  // ----------------------------------------------------------------------
  // Response generation
  // ----------------------------------------------------------------------
  assign dk = tx_idx - mbs_pkg::POS_START_LO;
  assign word_sel = start[2:0] + dk[3:1];

  always_comb begin
    tx_byte = 8'h00;
    bit_idx = 0;
    if (tx_idx == mbs_pkg::POS_ADDR) begin
      tx_byte = node_addr;
    end else if (tx_idx == mbs_pkg::POS_FUNC) begin
      tx_byte = (exc != mbs_pkg::EXC_NONE) ? (func | mbs_pkg::EXC_FLAG) : func;
    end else if (exc != mbs_pkg::EXC_NONE) begin
      tx_byte = exc;
    end else if (fn_echo) begin
      unique case (tx_idx)
        mbs_pkg::POS_START_HI: tx_byte = start[15:8];
        mbs_pkg::POS_START_LO: tx_byte = start[7:0];
        mbs_pkg::POS_CNT_HI: tx_byte = value[15:8];
        default: tx_byte = value[7:0];
      endcase
    end else if (tx_idx == mbs_pkg::POS_START_HI) begin
      tx_byte = 8'(resp_last - mbs_pkg::POS_START_HI);
    end else if (fn_words) begin
      if (func == mbs_pkg::FN_RD_HOLD) begin
        tx_byte = dk[0] ? hold_state[{word_sel, 4'h0} +: mbs_pkg::BYTE_W]
                        : hold_state[{word_sel, 4'h8} +: mbs_pkg::BYTE_W];
      end else begin
        tx_byte = dk[0] ? input_regs[{word_sel, 4'h0} +: mbs_pkg::BYTE_W]
                        : input_regs[{word_sel, 4'h8} +: mbs_pkg::BYTE_W];
      end
    end else begin
      // Unused high bits of the last byte stay zero
      for (int j = 0; j < mbs_pkg::BYTE_W; j++) begin
        bit_idx = int'(start) + int'(dk) * mbs_pkg::BYTE_W + j;
        if (bit_idx < int'(start) + int'(value) && bit_idx < mbs_pkg::N_COILS) begin
          tx_byte[j] = (func == mbs_pkg::FN_RD_COILS) ? coil_state[bit_idx]
                                                      : discrete_in[bit_idx];
        end
      end
    end
  end

  assign load = (state == mbs_pkg::ST_RESP) && room;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_idx <= mbs_pkg::POS_ADDR;
    end else if (state != mbs_pkg::ST_RESP) begin
      tx_idx <= mbs_pkg::POS_ADDR;
    end else if (load) begin
      tx_idx <= tx_idx + 5'h01;
    end
  end

  mbs_tx_byte u_tx (
    .clock(clock),
    .resetn(resetn),
    .load(load),
    .byte_in(tx_byte),
    .last_in(tx_idx == resp_last),
    .room(room),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last)
  );
endmodule // mbs_slave
`default_nettype wire

// >>> design/mbs_pkg.sv
package mbs_pkg;

  // ----------------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] FN_RD_COILS = 8'h01;
  localparam logic [7:0] FN_RD_DISC = 8'h02;
  localparam logic [7:0] FN_RD_HOLD = 8'h03;
  localparam logic [7:0] FN_RD_IREG = 8'h04;
  localparam logic [7:0] FN_WR_COIL = 8'h05;
  localparam logic [7:0] FN_WR_HOLD = 8'h06;
  localparam logic [7:0] FN_WR_COILS = 8'h0F;
  localparam logic [7:0] FN_WR_HOLDS = 8'h10;

  // ----------------------------------------------------------------------
  // Exception answers
  // ----------------------------------------------------------------------
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;

  // ----------------------------------------------------------------------
  // Node addresses and coil values
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hF7;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;

  // ----------------------------------------------------------------------
  // Storage sizes
  // ----------------------------------------------------------------------
  localparam int N_COILS = 16;
  localparam int N_DISC = 16;
  localparam int N_IREG = 8;
  localparam int N_HREG = 8;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int WBUF_DEPTH = 16;
  localparam logic [15:0] ONE_ITEM = 16'h0001;
  localparam logic [7:0] BYTE_ROUND = 8'h07;

  // ----------------------------------------------------------------------
  // Byte positions in request and response
  // ----------------------------------------------------------------------
  localparam logic [4:0] POS_ADDR = 5'h00;
  localparam logic [4:0] POS_FUNC = 5'h01;
  localparam logic [4:0] POS_START_HI = 5'h02;
  localparam logic [4:0] POS_START_LO = 5'h03;
  localparam logic [4:0] POS_CNT_HI = 5'h04;
  localparam logic [4:0] POS_CNT_LO = 5'h05;
  localparam logic [4:0] POS_BCNT = 5'h06;
  localparam logic [4:0] POS_DATA = 5'h07;
  localparam logic [4:0] LEN_FIXED = 5'h06;
  localparam logic [4:0] RX_IDX_MAX = 5'h1F;
  localparam logic [4:0] RSP_LAST_EXC = 5'h02;
  localparam logic [4:0] RSP_LAST_ECHO = 5'h05;

  // ----------------------------------------------------------------------
  // Engine states, Gray along idle, receive, execute, respond
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_EXEC = 2'b11,
    ST_RESP = 2'b10
  } mbs_state_t;

endpackage

// >>> design/mbs_range_check.sv
`timescale 1ns/1ps
`default_nettype none
module mbs_range_check #(
  parameter int SIZE = 16
) (
  // Requested span
  input wire logic [15:0] start,
  input wire logic [15:0] count,
  // Verdict
  output logic ok
);
  logic [16:0] end_excl;

  // Widened sum so a start near the top cannot wrap back into range
  assign end_excl = {1'b0, start} + {1'b0, count};
  assign ok = (count != 16'h0000) && (end_excl <= 17'(SIZE));
endmodule // mbs_range_check
`default_nettype wire

// >>> design/mbs_tx_byte.sv
`timescale 1ns/1ps
`default_nettype none
module mbs_tx_byte (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Engine side
  input wire logic load,
  input wire logic [7:0] byte_in,
  input wire logic last_in,
  output logic room,
  // Link side
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last
);
  // Single holding stage; link back-pressure stalls the engine through room
  assign room = !tx_valid || tx_ready;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
    end else if (room) begin
      tx_valid <= load;
      tx_data <= byte_in;
      tx_last <= last_in && load;
    end
  end
endmodule // mbs_tx_byte
`default_nettype wire

// >>> verification/mbs_slave_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Response engine checker
// ----------------------------------------------------------------------
module mbs_slave_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Request and response streams
  input wire logic [7:0] node_addr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  // Storage and status
  input wire logic [mbs_pkg::N_COILS-1:0] coil_state,
  input wire logic [mbs_pkg::N_HREG*mbs_pkg::WORD_W-1:0] hold_state,
  input wire logic busy,
  input wire logic write_done
);
  logic [4:0] rx_idx;
  logic [7:0] rx_func;
  logic [4:0] tx_cnt;
  // Bytes seen while busy are dropped by the engine, so they are not counted here
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_idx <= 5'h00;
      rx_func <= 8'h00;
    end else if (rx_valid && !busy) begin
      rx_idx <= rx_last ? 5'h00 : rx_idx + 5'h01;
      if (rx_idx == 5'h01) rx_func <= rx_data;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) tx_cnt <= 5'h00;
    else if (tx_valid && tx_ready) tx_cnt <= tx_last ? 5'h00 : tx_cnt + 5'h01;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_answer_start;
    $rose(busy) ##[1:3] $rose(tx_valid);
  endsequence
  a_answer_addr: assert property (s_answer_start |-> tx_data == node_addr)
    else $error("response does not open with node address");
  a_echo_func: assert property (tx_valid && tx_cnt == 5'h01 |-> tx_data[6:0] == rx_func[6:0])
    else $error("function code not echoed");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("response byte dropped before acceptance");
  a_silent_idle: assert property ($rose(tx_valid) |-> busy || $past(busy))
    else $error("transmit outside an answer");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:400] !busy)
    else $error("command never completes");
  a_last_idle: assert property (tx_valid && tx_last |-> ##[0:2] !busy)
    else $error("busy stays up past last byte");
  a_done_pulse: assert property (write_done |=> !write_done)
    else $error("write done longer than one cycle");
  a_coil_write: assert property ($changed(coil_state) |-> ##[0:2] write_done)
    else $error("coil change without write");
  a_hold_write: assert property ($changed(hold_state) |-> ##[0:2] write_done)
    else $error("holding change without write");
endmodule // mbs_slave_chk
bind mbs_slave mbs_slave_chk u_chk (.clock(clock), .resetn(resetn), .node_addr(node_addr),
  .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .tx_ready(tx_ready),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .coil_state(coil_state),
  .hold_state(hold_state), .busy(busy), .write_done(write_done));
`default_nettype wire

// >>> verification/mbs_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Polling master, drives at the falling edge
// ----------------------------------------------------------------------
module mbs_master_model (
  input wire logic clock,
  output var logic rx_valid,
  output var logic [7:0] rx_data,
  output var logic rx_last,
  output var logic rx_error,
  output var logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  int seed = 80;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    rx_error = 1'b0;
    tx_ready = 1'b0;
  end
  // Only this side starts a transfer; request bytes go out in caller order
  task automatic xfer(input logic [7:0] q[$], input bit err, output logic [7:0] r[$]);
    int i;
    int w;
    bit done;
    r = {};
    for (i = 0; i < q.size(); i++) begin
      @(negedge clock);
      rx_valid = 1'b1;
      rx_data = q[i];
      rx_last = (i == q.size() - 1);
      rx_error = err && rx_last;
    end
    @(negedge clock);
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_error = 1'b0;
    rx_data = ~rx_data;
    // Wait for the answer or give up after 40 cycles with no accepted byte
    w = 0;
    done = 0;
    while (!done && w < 40) begin
      @(negedge clock);
      tx_ready = ($random(seed) & 3) != 0;
      rx_data = ~rx_data;
      if (tx_valid && tx_ready) begin
        r.push_back(tx_data);
        done = tx_last;
        w = 0;
      end else w++;
    end
    @(posedge clock);
  endtask
endmodule // mbs_master_model
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Bench with reference model
// ----------------------------------------------------------------------
module tb_top;
  logic clock = 1'b0;
  logic resetn;
  logic [7:0] node;
  logic [15:0] disc;
  logic [127:0] iregs;
  logic rx_valid, rx_last, rx_error, tx_ready, tx_valid, tx_last, busy, write_done;
  logic [7:0] rx_data, tx_data;
  logic [15:0] coil_state;
  logic [127:0] hold_state;
  logic coil [16];
  logic [15:0] hreg [8];
  logic [7:0] q[$];
  int seed = 80;
  int fail_count = 0;
  int tests_run = 0;
  int i, s;
  always #2 clock = ~clock;
  mbs_slave uut (.clock(clock), .resetn(resetn), .node_addr(node), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_error(rx_error), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .discrete_in(disc),
    .input_regs(iregs), .coil_state(coil_state), .hold_state(hold_state), .busy(busy),
    .write_done(write_done));
  mbs_master_model mdl (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_error(rx_error), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last));
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Expected answer and storage update, worked out byte by byte
  task automatic model(input logic [7:0] q[$], output logic [7:0] e[$]);
    int f, s, n, k, lim;
    logic [7:0] b;
    logic [15:0] v;
    e = {};
    // Frames for another node are neither answered nor applied
    if (q[0] != node && q[0] != 8'h00) return;
    f = q[1];
    s = {q[2], q[3]};
    n = (f == 5 || f == 6) ? 1 : {q[4], q[5]};
    lim = (f == 3 || f == 4 || f == 6 || f == 16) ? 8 : 16;
    e = {q[0], q[1]};
    if (!(f inside {1, 2, 3, 4, 5, 6, 15, 16})) e = {q[0], q[1] | 8'h80, 8'h01};
    else if (n == 0 || s + n > lim) e = {q[0], q[1] | 8'h80, 8'h02};
    else if ((f == 5 && {q[4], q[5]} != 16'hFF00 && {q[4], q[5]} != 16'h0000)
             || (f == 15 && q[6] != 8'((n + 7) / 8)) || (f == 16 && q[6] != 8'(2 * n)))
      e = {q[0], q[1] | 8'h80, 8'h03};
    else if (f < 3) begin
      e.push_back(8'((n + 7) / 8));
      for (k = 0; k < (n + 7) / 8 * 8; k++) begin
        if (k % 8 == 0) b = 8'h00;
        if (k < n) b[k % 8] = (f == 1) ? coil[s + k] : disc[s + k];
        if (k % 8 == 7) e.push_back(b);
      end
    end else if (f < 5) begin
      e.push_back(8'(2 * n));
      for (k = 0; k < n; k++) begin
        v = (f == 3) ? hreg[s + k] : iregs[16 * (s + k) +: 16];
        e.push_back(v[15:8]);
        e.push_back(v[7:0]);
      end
    end else begin
      if (f == 5) coil[s] = (q[4] == 8'hFF);
      if (f == 6) hreg[s] = {q[4], q[5]};
      for (k = 0; k < n && f == 15; k++) coil[s + k] = q[7 + k / 8][k % 8];
      for (k = 0; k < n && f == 16; k++) hreg[s + k] = {q[7 + 2 * k], q[8 + 2 * k]};
      for (k = 2; k < 6; k++) e.push_back(q[k]);
    end
    if (q[0] == 8'h00) e = {};
  endtask
  task automatic run(input logic [7:0] q[$], input bit err);
    logic [7:0] e[$];
    logic [7:0] r[$];
    logic [15:0] cv;
    logic [127:0] hv;
    int k;
    e = {};
    if (!err) model(q, e);
    mdl.xfer(q, err, r);
    chk("rsp_len", 128'(r.size()), 128'(e.size()));
    for (k = 0; k < e.size(); k++) chk("rsp_byte", 128'(r[k]), 128'(e[k]));
    for (k = 0; k < 16; k++) cv[k] = coil[k];
    for (k = 0; k < 8; k++) hv[16 * k +: 16] = hreg[k];
    chk("coils", 128'(coil_state), 128'(cv));
    chk("holds", hold_state, hv);
    chk("busy", 128'(busy), 128'(0));
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    fail_count++;
    final_report;
  end
  initial begin
    resetn = 1'b0;
    node = 8'h2A;
    disc = 16'($random(seed));
    iregs = {$random(seed), $random(seed), $random(seed), $random(seed)};
    for (i = 0; i < 16; i++) coil[i] = 1'b0;
    for (i = 0; i < 8; i++) hreg[i] = 16'h0000;
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    for (i = 0; i < 8; i++) run({node, 8'h06, 8'h00, 8'(i), 8'($random(seed)), 8'(i)}, 0);
    run({node, 8'h03, 8'h00, 8'h00, 8'h00, 8'h08}, 0);
    run({node, 8'h04, 8'h00, 8'h03, 8'h00, 8'h05}, 0);
    run({node, 8'h02, 8'h00, 8'h00, 8'h00, 8'h10}, 0);
    run({node, 8'h05, 8'h00, 8'h0F, 8'hFF, 8'h00}, 0);
    run({node, 8'h05, 8'h00, 8'h0F, 8'h00, 8'h00}, 0);
    run({node, 8'h0F, 8'h00, 8'h03, 8'h00, 8'h0A, 8'h02, 8'h5B, 8'($random(seed))}, 0);
    run({node, 8'h01, 8'h00, 8'h01, 8'h00, 8'h0F}, 0);
    q = {node, 8'h10, 8'h00, 8'h00, 8'h00, 8'h08, 8'h10};
    for (i = 0; i < 16; i++) q.push_back(8'($random(seed)));
    run(q, 0);
    run({8'h00, 8'h06, 8'h00, 8'h02, 8'h12, 8'h34}, 0);
    run({8'h2B, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 0);
    run({node, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, 0);
    run({node, 8'h03, 8'h00, 8'h07, 8'h00, 8'h02}, 0);
    run({node, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
    run({node, 8'h05, 8'h00, 8'h01, 8'h12, 8'h34}, 0);
    run({node, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h01, 8'hA5}, 0);
    run({node, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1);
    for (i = 0; i < 20; i++) begin
      s = {$random(seed)} % 8;
      run({node, 8'(3 + i % 2), 8'h00, 8'(s), 8'h00, 8'(1 + {$random(seed)} % (8 - s))}, 0);
    end
    final_report;
  end
endmodule // tb_top
`default_nettype wire
